// *** verilog/led_seq_pkg.sv ***
/*
 * Constants for the LED boost enable sequencer: clock rate, wake, shutdown and
 * soft-start timing, oscillator periods and state codes.
 * Assumes a single 125 MHz clock and analog comparators that report as levels.
 */
package led_seq_pkg;
    localparam int CLK_MHZ = 125;
    localparam int WAKE_US = 100;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int OFF_MS = 10;
    localparam int OFF_CYC = OFF_MS * 1000 * CLK_MHZ;
    localparam int SS_MS = 3;
    localparam int SS_CYC = SS_MS * 1000 * CLK_MHZ;
    localparam int SS_STEPS = 8;
    // Feedback comparator trips at this share of nominal, in percent
    localparam int FB_EARLY_PCT = 75;
    localparam int FDEF_KHZ = 600;
    localparam int FMAX_KHZ = 1000;
    localparam int FMIN_KHZ = 100;
    localparam logic [10:0] PER_DEF = 11'(CLK_MHZ * 1000 / FDEF_KHZ);
    localparam logic [10:0] PER_MIN = 11'(CLK_MHZ * 1000 / FMAX_KHZ);
    localparam logic [10:0] PER_MAX = 11'(CLK_MHZ * 1000 / FMIN_KHZ);
    localparam int SYNC_MIN_NS = 250;
    localparam int SYNC_MIN_CYC = (SYNC_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_W = 6;
    localparam logic [1:0] SRC_RES = 2'h0;
    localparam logic [1:0] SRC_HIGH = 2'h1;
    localparam logic [1:0] SRC_SYNC = 2'h2;
    localparam logic [2:0] STEP_FULL = 3'h7;

    typedef enum logic [3:0] {
        ST_SHDN = 4'h1,
        ST_WAKE = 4'h2,
        ST_SOFT = 4'h4,
        ST_RUN = 4'h8
    } seq_state_e;
endpackage : led_seq_pkg

// *** verilog/switch_freq_osc.sv ***
/*
 * Switching-frequency pulse generator: resistor-set period, tied-high default
 * or edge-locked external sync.
 * Assumes the sync level is already synchronised and the period word is static.
 */
`timescale 1ns/1ns
module switch_freq_osc
    import led_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [1:0] src,
    input wire logic [10:0] res_period,
    input wire logic sync_lvl,
    output logic sw_pulse
);
    logic [10:0] cnt_ff, nxt_cnt;
    logic pulse_ff, nxt_pulse;
    logic sync_prev_ff;
    logic [10:0] period;

    always_comb begin
        // Out-of-range resistor codes clamp to the supported band
        if (src == SRC_HIGH) begin
            period = PER_DEF;
        end else if (res_period < PER_MIN) begin
            period = PER_MIN;
        end else if (res_period > PER_MAX) begin
            period = PER_MAX;
        end else begin
            period = res_period;
        end
        nxt_cnt = cnt_ff;
        nxt_pulse = 1'b0;
        if (!run) begin
            nxt_cnt = '0;
        end else if (src == SRC_SYNC) begin
            // Locks to each rising edge; pulse is one clock cycle wide
            nxt_pulse = sync_lvl && !sync_prev_ff;
            nxt_cnt = '0;
        end else if (cnt_ff >= period - 11'h1) begin
            nxt_cnt = '0;
            nxt_pulse = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + 11'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            pulse_ff <= 1'b0;
            sync_prev_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            pulse_ff <= nxt_pulse;
            sync_prev_ff <= sync_lvl;
        end
    end

    assign sw_pulse = pulse_ff;
endmodule : switch_freq_osc

// *** verilog/led_boost_enable_sequencer.sv ***
/*
 * Enable, shutdown and soft-start sequencer of a single-string LED boost driver.
 * Assumes rail, feedback and analog-dim comparators arrive as asynchronous levels,
 * and the host drives the dimming input as a plain logic pin.
 */
`timescale 1ns/1ns
module led_boost_enable_sequencer
    import led_seq_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC,
    parameter int OFF_CYCLES = OFF_CYC,
    parameter int SS_CYCLES = SS_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic DIM_ENABLE_INPUT,
    input wire logic CORE_SUPPLY_RAIL_OK,
    input wire logic GATE_SUPPLY_RAIL_OK,
    input wire logic FB_EARLY_REACHED,
    input wire logic ANALOG_DIM_INPUT_LOW,
    input wire logic [1:0] FREQ_SELECT_SRC,
    input wire logic [10:0] FREQ_RES_PERIOD,
    input wire logic FREQ_SELECT_PIN,
    output logic CORE_REG_EN,
    output logic GATE_REG_EN,
    output logic FAULT_FLAG_N_O,
    output logic FAULT_FLAG_N_OE,
    output logic DIM_SWITCH_DRIVE,
    output logic BOOST_EN,
    output logic [2:0] CURRENT_LIMIT_STEP,
    output logic SOFT_START_DONE,
    output logic SW_PULSE
);
    localparam logic [13:0] WAKE_LAST = 14'(WAKE_CYCLES - 1);
    localparam logic [20:0] OFF_LOAD = 21'(OFF_CYCLES);
    localparam logic [20:0] OFF_ONE = 21'h1;
    localparam logic [18:0] SS_LAST = 19'(SS_CYCLES - 1);
    localparam logic [18:0] SS_STEP_LEN = 19'(SS_CYCLES / SS_STEPS);

    // Two-stage synchronisers; only stage two is read
    logic [SYNC_W-1:0] meta_ff, sync_ff;
    logic dim_s, core_s, gate_s, fb_s, ana_low_s, fsel_s;
    logic rails_ok;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= {FREQ_SELECT_PIN, ANALOG_DIM_INPUT_LOW, FB_EARLY_REACHED,
                        GATE_SUPPLY_RAIL_OK, CORE_SUPPLY_RAIL_OK, DIM_ENABLE_INPUT};
            sync_ff <= meta_ff;
        end
    end

    assign dim_s = sync_ff[0];
    assign core_s = sync_ff[1];
    assign gate_s = sync_ff[2];
    assign fb_s = sync_ff[3];
    assign ana_low_s = sync_ff[4];
    assign fsel_s = sync_ff[5];
    assign rails_ok = core_s && gate_s;

    function automatic logic [2:0] limit_step(input logic [18:0] cnt);
        logic [18:0] q;
        q = cnt / SS_STEP_LEN;
        if (q > 19'(STEP_FULL)) begin
            limit_step = STEP_FULL;
        end else begin
            limit_step = q[2:0];
        end
    endfunction : limit_step

    seq_state_e state_ff, nxt_state;
    logic [13:0] hi_cnt_ff, nxt_hi_cnt;
    logic [20:0] off_cnt_ff, nxt_off_cnt;
    logic [18:0] ss_cnt_ff, nxt_ss_cnt;
    logic reg_en_ff, nxt_reg_en;
    logic fault_ff, nxt_fault;
    logic drive_ff, nxt_drive;
    logic boost_ff, nxt_boost;
    logic [2:0] step_ff, nxt_step;
    logic done_ff, nxt_done;
    logic active;

    always_comb begin
        nxt_state = state_ff;
        nxt_hi_cnt = '0;
        nxt_off_cnt = off_cnt_ff;
        nxt_ss_cnt = ss_cnt_ff;
        case (state_ff)
            ST_SHDN: begin
                nxt_off_cnt = OFF_LOAD;
                nxt_ss_cnt = '0;
                // Short glitches never wake the part: the pulse must stay high
                if (dim_s && hi_cnt_ff == WAKE_LAST) begin
                    nxt_state = ST_WAKE;
                    nxt_off_cnt = OFF_LOAD;
                end else if (dim_s) begin
                    nxt_hi_cnt = hi_cnt_ff + 14'h1;
                end
            end
            ST_WAKE: begin
                nxt_ss_cnt = '0;
                if (rails_ok) begin
                    nxt_state = ST_SOFT;
                end
            end
            ST_SOFT: begin
                if (!rails_ok) begin
                    nxt_state = ST_WAKE;
                end else if (fb_s || ss_cnt_ff == SS_LAST) begin
                    nxt_state = ST_RUN;
                end else begin
                    nxt_ss_cnt = ss_cnt_ff + 19'h1;
                end
            end
            ST_RUN: begin
                if (!rails_ok) begin
                    nxt_state = ST_WAKE;
                end
            end
            default: begin
                nxt_state = ST_SHDN;
            end
        endcase
        if (state_ff != ST_SHDN) begin
            // High level keeps the timer cleared; each low stretch runs it down
            if (dim_s) begin
                nxt_off_cnt = OFF_LOAD;
            end else if (off_cnt_ff == OFF_ONE) begin
                nxt_state = ST_SHDN;
                nxt_off_cnt = OFF_LOAD;
            end else begin
                nxt_off_cnt = off_cnt_ff - OFF_ONE;
            end
        end
    end

    always_comb begin
        active = nxt_state != ST_SHDN;
        nxt_reg_en = active;
        nxt_fault = active && !rails_ok;
        nxt_drive = active && rails_ok && dim_s && !ana_low_s;
        nxt_boost = (nxt_state == ST_SOFT || nxt_state == ST_RUN)
                    && dim_s && !ana_low_s;
        nxt_done = nxt_state == ST_RUN;
        if (nxt_state == ST_RUN) begin
            nxt_step = STEP_FULL;
        end else if (nxt_state == ST_SOFT) begin
            nxt_step = limit_step(nxt_ss_cnt);
        end else begin
            nxt_step = '0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff <= ST_SHDN;
            hi_cnt_ff <= '0;
            off_cnt_ff <= '0;
            ss_cnt_ff <= '0;
            reg_en_ff <= 1'b0;
            fault_ff <= 1'b0;
            drive_ff <= 1'b0;
            boost_ff <= 1'b0;
            step_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            hi_cnt_ff <= nxt_hi_cnt;
            off_cnt_ff <= nxt_off_cnt;
            ss_cnt_ff <= nxt_ss_cnt;
            reg_en_ff <= nxt_reg_en;
            fault_ff <= nxt_fault;
            drive_ff <= nxt_drive;
            boost_ff <= nxt_boost;
            step_ff <= nxt_step;
            done_ff <= nxt_done;
        end
    end

    switch_freq_osc u_osc (
        .clk(CLK),
        .rst_n(RST_N),
        .run(boost_ff),
        .src(FREQ_SELECT_SRC),
        .res_period(FREQ_RES_PERIOD),
        .sync_lvl(fsel_s),
        .sw_pulse(SW_PULSE)
    );

    assign CORE_REG_EN = reg_en_ff;
    assign GATE_REG_EN = reg_en_ff;
    // Open drain: only ever pulls low
    assign FAULT_FLAG_N_O = 1'b0;
    assign FAULT_FLAG_N_OE = fault_ff;
    assign DIM_SWITCH_DRIVE = drive_ff;
    assign BOOST_EN = boost_ff;
    assign CURRENT_LIMIT_STEP = step_ff;
    assign SOFT_START_DONE = done_ff;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_soft_ready;
        state_ff == ST_SOFT && rails_ok;
    endsequence

    sequence s_wake_seen;
        state_ff == ST_SHDN ##1 state_ff == ST_WAKE;
    endsequence

    sequence s_short_high;
        state_ff == ST_SHDN && hi_cnt_ff != WAKE_LAST;
    endsequence

    sequence s_low_tick;
        state_ff != ST_SHDN && !dim_s && off_cnt_ff != OFF_ONE;
    endsequence

    chk_wake_qualify: assert property (
        s_wake_seen |-> $past(dim_s) && $past(hi_cnt_ff) == WAKE_LAST)
        else $error("wake without qualified pulse");
    chk_reg_enable: assert property (
        CORE_REG_EN == (state_ff != ST_SHDN) && GATE_REG_EN == CORE_REG_EN)
        else $error("regulator enable disagrees with state");
    chk_off_expire: assert property (
        (state_ff != ST_SHDN && !dim_s && off_cnt_ff == OFF_ONE) |=> state_ff == ST_SHDN)
        else $error("shutdown timer expiry missed");
    chk_timer_clear: assert property (
        (state_ff != ST_SHDN && dim_s) ##1 state_ff != ST_SHDN |-> off_cnt_ff == OFF_LOAD)
        else $error("shutdown timer not cleared by high input");
    chk_uv_fault: assert property (
        (state_ff != ST_SHDN && !rails_ok) ##1 state_ff != ST_SHDN
        |-> FAULT_FLAG_N_OE && !BOOST_EN && !DIM_SWITCH_DRIVE)
        else $error("undervoltage not flagged");
    chk_soft_gate: assert property (
        $rose(state_ff == ST_SOFT) |-> $past(rails_ok) && $past(state_ff) == ST_WAKE)
        else $error("soft-start began with rails low");
    chk_soft_bound: assert property (
        s_soft_ready ##0 ss_cnt_ff == SS_LAST ##0 (dim_s || off_cnt_ff != OFF_ONE)
        |=> state_ff == ST_RUN && CURRENT_LIMIT_STEP == STEP_FULL)
        else $error("soft-start overran its period");
    chk_soft_early: assert property (
        s_soft_ready ##0 fb_s |=> state_ff == ST_RUN || state_ff == ST_SHDN)
        else $error("soft-start did not end at feedback threshold");
    chk_ana_off: assert property (
        ana_low_s |=> !DIM_SWITCH_DRIVE && !BOOST_EN)
        else $error("drives not forced low by analog dim");
    chk_dim_follow: assert property (
        (state_ff == ST_RUN && rails_ok && !ana_low_s) |=> DIM_SWITCH_DRIVE == $past(dim_s)
        && BOOST_EN == ($past(dim_s) && state_ff != ST_SHDN))
        else $error("drives do not follow dimming input");
    chk_shdn_quiet: assert property (
        state_ff == ST_SHDN |-> !DIM_SWITCH_DRIVE && !BOOST_EN && !FAULT_FLAG_N_OE
        && !SOFT_START_DONE)
        else $error("outputs active in shutdown");

    // Wake, timer, regulator and boost sequencing
    chk_wake_refuse: assert property (
        s_short_high |=> state_ff == ST_SHDN)
        else $error("woke before the pulse qualified");
    chk_hi_restart: assert property (
        state_ff == ST_SHDN && !dim_s |=> hi_cnt_ff == '0)
        else $error("high count survived a low sample");
    chk_timer_count: assert property (
        s_low_tick |=> off_cnt_ff == $past(off_cnt_ff) - OFF_ONE && state_ff != ST_SHDN)
        else $error("shutdown timer did not count down");
    chk_wake_reload: assert property (
        s_wake_seen |-> off_cnt_ff == OFF_LOAD && CORE_REG_EN && GATE_REG_EN)
        else $error("wake did not clear timer and enable regulators");
    chk_reg_drop: assert property (
        $fell(CORE_REG_EN) |-> $past(!dim_s) && $past(off_cnt_ff) == OFF_ONE)
        else $error("regulators dropped before timer expiry");
    chk_boost_state: assert property (
        BOOST_EN |-> state_ff == ST_SOFT || state_ff == ST_RUN)
        else $error("boost enabled outside soft-start and run");
    chk_osc_idle: assert property (
        !BOOST_EN |=> !SW_PULSE)
        else $error("switching pulse while boost is off");

    // Soft-start, rails and drives; a timer expiry may cut any of them short
    chk_step_start: assert property (
        $rose(state_ff == ST_SOFT) |-> CURRENT_LIMIT_STEP == '0 && !SOFT_START_DONE)
        else $error("soft-start did not begin at the lowest step");
    chk_step_climb: assert property (
        state_ff == ST_SOFT ##1 state_ff == ST_SOFT |-> CURRENT_LIMIT_STEP >= $past(CURRENT_LIMIT_STEP))
        else $error("current limit step went down");
    chk_done_full: assert property (
        SOFT_START_DONE |-> CURRENT_LIMIT_STEP == STEP_FULL)
        else $error("run without full current limit");
    chk_fault_clear: assert property (
        rails_ok |=> !FAULT_FLAG_N_OE)
        else $error("fault held with rails good");
    chk_rail_back: assert property (
        (state_ff == ST_SOFT || state_ff == ST_RUN) && !rails_ok
        |=> state_ff == ST_WAKE || state_ff == ST_SHDN)
        else $error("operation not inhibited on undervoltage");
    chk_drive_rails: assert property (
        !rails_ok |=> !DIM_SWITCH_DRIVE)
        else $error("switch drive active with a rail low");
    chk_soft_wait: assert property (
        state_ff == ST_WAKE && !rails_ok |=> state_ff != ST_SOFT && !BOOST_EN)
        else $error("soft-start entered with a rail low");
endmodule : led_boost_enable_sequencer

// *** test/dim_host_model.sv ***
/*
 * Host model: drives the dimming input and the external sync clock.
 * Assumes the bench calls its tasks at a falling CLK edge.
 */
`timescale 1ns/1ns
module dim_host_model (
    input wire logic clk,
    output logic dim,
    output logic sync
);
    initial begin
        dim = 1'b0;
        sync = 1'b0;
    end

    // Holds a level for n cycles; a wake pulse is simply a long high
    task automatic drive(input logic lvl, input int n);
        dim = lvl;
        repeat (n) @(negedge clk);
    endtask : drive

    // 32 cycles high is the 250 ns minimum; 400-cycle period is in range
    task automatic sync_burst(input int k);
        repeat (k) begin
            sync = 1'b1;
            repeat (32) @(negedge clk);
            sync = 1'b0;
            repeat (368) @(negedge clk);
        end
    endtask : sync_burst
endmodule : dim_host_model

// *** test/led_boost_enable_sequencer_tb_top.sv ***
/*
 * Self-checking bench for the LED boost enable sequencer.
 * Assumes short counts: wake 20, shutdown 200, soft-start 80 cycles.
 */
`timescale 1ns/1ns
module led_boost_enable_sequencer_tb_top;
    import led_seq_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic core_ok = 1'b1;
    logic gate_ok = 1'b1;
    logic fb = 1'b0;
    logic ana_low = 1'b0;
    logic [1:0] src = SRC_HIGH;
    logic [10:0] res_per = 11'h12c;
    logic dim, sync, reg_core, reg_gate, flt_o, flt_oe, drv, boost, done, swp;
    logic [2:0] step;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    dim_host_model i_host (.clk(clk), .dim(dim), .sync(sync));

    led_boost_enable_sequencer #(.WAKE_CYCLES(20), .OFF_CYCLES(200), .SS_CYCLES(80)) i_dut (
        .CLK(clk), .RST_N(rst_n), .DIM_ENABLE_INPUT(dim),
        .CORE_SUPPLY_RAIL_OK(core_ok), .GATE_SUPPLY_RAIL_OK(gate_ok),
        .FB_EARLY_REACHED(fb), .ANALOG_DIM_INPUT_LOW(ana_low),
        .FREQ_SELECT_SRC(src), .FREQ_RES_PERIOD(res_per), .FREQ_SELECT_PIN(sync),
        .CORE_REG_EN(reg_core), .GATE_REG_EN(reg_gate), .FAULT_FLAG_N_O(flt_o),
        .FAULT_FLAG_N_OE(flt_oe), .DIM_SWITCH_DRIVE(drv), .BOOST_EN(boost),
        .CURRENT_LIMIT_STEP(step), .SOFT_START_DONE(done), .SW_PULSE(swp));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // Hang guard: the whole run needs well under 10000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk

    // Strap is static, so each frequency source gets its own reset
    task automatic boot(input logic [1:0] s, input logic [10:0] p);
        src = s;
        res_per = p;
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
    endtask : boot

    task automatic t_refuse();
        i_host.drive(1'b1, 10);
        i_host.drive(1'b0, 40);
        chk(reg_core === 1'b0 && flt_oe === 1'b0, "short pulse woke");
        $display("end refuse");
    endtask : t_refuse

    task automatic t_wake();
        i_host.drive(1'b1, 24);
        chk(reg_core === 1'b1 && reg_gate === 1'b1, "no wake");
        i_host.drive(1'b1, 40);
        chk(step > 3'h0 && step < STEP_FULL && done === 1'b0, "step mid");
        chk(drv === 1'b1 && boost === 1'b1, "drive in soft");
        i_host.drive(1'b1, 50);
        chk(done === 1'b1 && step === STEP_FULL, "soft end");
        i_host.drive(1'b0, 5);
        chk(drv === 1'b0 && boost === 1'b0, "low follow");
        i_host.drive(1'b1, 5);
        chk(drv === 1'b1 && boost === 1'b1, "high follow");
        $display("end wake");
    endtask : t_wake

    task automatic t_timer();
        i_host.drive(1'b0, 150);
        chk(reg_core === 1'b1, "early off");
        i_host.drive(1'b1, 3);
        i_host.drive(1'b0, 150);
        chk(reg_core === 1'b1, "no reload");
        i_host.drive(1'b0, 60);
        chk(reg_core === 1'b0 && reg_gate === 1'b0, "no shutdown");
        chk(drv === 1'b0 && boost === 1'b0 && flt_oe === 1'b0, "shdn outs");
        $display("end timer");
    endtask : t_timer

    task automatic t_rail();
        i_host.drive(1'b1, 130);
        gate_ok = 1'b0;
        i_host.drive(1'b1, 5);
        chk(flt_oe === 1'b1 && flt_o === 1'b0 && drv === 1'b0, "gate uv");
        gate_ok = 1'b1;
        core_ok = 1'b0;
        i_host.drive(1'b1, 5);
        chk(flt_oe === 1'b1 && boost === 1'b0, "core uv");
        core_ok = 1'b1;
        i_host.drive(1'b1, 5);
        chk(flt_oe === 1'b0 && done === 1'b0 && step === 3'h0, "restart");
        fb = 1'b1;
        i_host.drive(1'b1, 5);
        chk(done === 1'b1 && step === STEP_FULL, "early end");
        fb = 1'b0;
        ana_low = 1'b1;
        i_host.drive(1'b1, 5);
        chk(drv === 1'b0 && boost === 1'b0 && reg_core === 1'b1, "analog dim low");
        ana_low = 1'b0;
        i_host.drive(1'b1, 5);
        chk(drv === 1'b1 && done === 1'b1, "analog dim back");
        i_host.drive(1'b0, 210);
        $display("end rail");
    endtask : t_rail

    task automatic t_gate_wait();
        gate_ok = 1'b0;
        i_host.drive(1'b1, 24);
        chk(reg_core === 1'b1, "wake gate low");
        i_host.drive(1'b1, 100);
        chk(done === 1'b0 && boost === 1'b0 && step === 3'h0, "soft w/o gate");
        gate_ok = 1'b1;
        i_host.drive(1'b1, 100);
        chk(done === 1'b1, "soft after gate");
        $display("end gate wait");
    endtask : t_gate_wait

    task automatic period_is(input int exp, input string m);
        int n;
        n = 0;
        while (swp !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        n = 1;
        while (swp !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk(n == exp, m);
    endtask : period_is

    task automatic t_freq();
        period_is(int'(PER_DEF), "default");
        boot(SRC_RES, 11'h12c);
        i_host.drive(1'b1, 130);
        period_is(300, "resistor");
        boot(SRC_RES, 11'h064);
        i_host.drive(1'b1, 130);
        period_is(int'(PER_MIN), "clamp");
        boot(SRC_SYNC, 11'h12c);
        i_host.drive(1'b1, 130);
        fork
            i_host.sync_burst(4);
            period_is(400, "sync");
        join
        $display("end freq");
    endtask : t_freq

    initial begin
        boot(SRC_HIGH, 11'h12c);
        t_refuse();
        t_wake();
        t_timer();
        t_rail();
        t_gate_wait();
        t_freq();
        give_verdict();
    end
endmodule : led_boost_enable_sequencer_tb_top
